//--- design/ubprs_led_stretch.sv
// ubprs_led_stretch: stretches an activity level into an open-collector pulse
// assumes activity comes from logic on the same clock
`timescale 1ns/1ps
module ubprs_led_stretch
#(
	parameter int PULSE_CYCLES = ubprs_pkg::LED_PULSE_CYC
)
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	// activity in, led drive out (low = lit)
	input wire logic active_in,
	output logic led_n_out
);
	typedef struct packed {
		logic [ubprs_pkg::LED_CNT_W-1:0] cnt;
		logic led_n;
	} ubprs_led_state_t;

	ubprs_led_state_t state_r;
	ubprs_led_state_t state_nxt;

	// reload on activity so back-to-back transfers merge into one pulse
	always_comb
	begin
		state_nxt = state_r;
		if (active_in)
		begin
			state_nxt.cnt = ubprs_pkg::LED_CNT_W'(PULSE_CYCLES);
		end
		else if (state_r.cnt != '0)
		begin
			state_nxt.cnt = state_r.cnt - 1'b1;
		end
		state_nxt.led_n = !(active_in ||
			state_r.cnt > ubprs_pkg::LED_CNT_W'(1));
	end

	// state register
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state_r <= '{cnt: '0, led_n: 1'b1};
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	assign led_n_out = state_r.led_n;
endmodule : ubprs_led_stretch

//--- design/ubprs_pkg.sv
// ubprs_pkg: constants and carrier types for the power/reset/status block
// assumes a 100 MHz system clock; no imports are made from it
package ubprs_pkg;
	// system clock period
	localparam int CLK_PERIOD_NS = 10;
	// reset output release delay after supply and clock are good
	localparam int RST_HOLD_US = 2000;
	localparam int RST_HOLD_CYC = (RST_HOLD_US * 1000) / CLK_PERIOD_NS;
	// minimum visible activity led pulse
	localparam int LED_PULSE_US = 50000;
	localparam int LED_PULSE_CYC = (LED_PULSE_US * 1000) / CLK_PERIOD_NS;
	// counter widths
	localparam int RST_CNT_W = 24;
	localparam int LED_CNT_W = 24;
	// oscillator output half period in system cycles (100/12 ~ 8 per half)
	localparam int OSC_HALF_CYC = 8;
	localparam int OSC_CNT_W = 4;
	// synchroniser depth for pin inputs
	localparam int SYNC_DEPTH = 3;

	// reset output sequencer states
	typedef enum logic [1:0] {
		UBPRS_RST_WAIT,
		UBPRS_RST_HOLD,
		UBPRS_RST_DRIVE
	} ubprs_rst_state_t;

	// usb side status inputs
	typedef struct packed {
		logic suspended;
		logic configured;
		logic bus_reset;
		logic tx_active;
		logic rx_active;
	} ubprs_usb_status_t;

	// pin-level outputs with their enables
	typedef struct packed {
		logic reset_output;
		logic reset_output_oe;
		logic eeprom_oe;
		logic power_enable_n;
		logic suspend_n;
		logic tx_activity_led_n;
		logic rx_activity_led_n;
		logic oscillator_output;
	} ubprs_pins_t;
endpackage : ubprs_pkg

//--- design/ubprs_top.sv
// ubprs_top: power, reset and status outputs of the usb serial bridge
// assumes usb status comes from same-clock logic; pins are synchronised
// Contract
// - During reset the eeprom pins float; otherwise the clock is driven.
// - The suspend indicator is low while suspended and high otherwise.
// - Power enable goes low once configured and back high in suspend.
// - The board straps power select low for bus, high for self powered.
// - External reset is active low and is tied high when unused.
// - Reset output floats about 2ms after supply and clock, then drives.
// - External reset low forces the reset output back to float.
// - A usb bus reset does not affect the reset output.
// - The transmit led pulses low while usb data is sent.
// - The receive led pulses low while usb data is received.
// - The oscillator output stops toggling while suspended.
`timescale 1ns/1ps
module ubprs_top
#(
	parameter int RST_HOLD_CYCLES = ubprs_pkg::RST_HOLD_CYC,
	parameter int LED_PULSE_CYCLES = ubprs_pkg::LED_PULSE_CYC
)
(
	// clock and power-on reset
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	// board pins
	input wire logic external_reset_n_in,
	input wire logic power_source_select_in,
	input wire logic supply_good_in,
	input wire logic test_mode_in,
	// usb engine status
	input wire ubprs_pkg::ubprs_usb_status_t usb_status_in,
	// eeprom pins
	output logic eeprom_serial_clock_out,
	output logic eeprom_serial_clock_oe_out,
	output logic eeprom_chip_select_oe_out,
	output logic eeprom_data_io_oe_out,
	// reset output pin
	output logic reset_output_out,
	output logic reset_output_oe_out,
	// power control pins
	output logic suspend_n_out,
	output logic power_enable_n_out,
	output logic self_powered_out,
	output logic test_mode_out,
	// leds, open collector: oe high pulls the pin low
	output logic tx_activity_led_n_oe_out,
	output logic rx_activity_led_n_oe_out,
	// oscillator output
	output logic oscillator_output_out
);
	typedef struct packed {
		logic [ubprs_pkg::SYNC_DEPTH-1:0] ext_rst_sync;
		logic [ubprs_pkg::SYNC_DEPTH-1:0] supply_sync;
		logic [ubprs_pkg::SYNC_DEPTH-1:0] psel_sync;
		logic [ubprs_pkg::SYNC_DEPTH-1:0] test_sync;
		logic ext_rst_n;
		logic supply_ok;
		logic self_powered;
		logic test_mode;
		ubprs_pkg::ubprs_rst_state_t rst_state;
		logic [ubprs_pkg::RST_CNT_W-1:0] rst_cnt;
		logic pwr_en_n;
		logic [ubprs_pkg::OSC_CNT_W-1:0] osc_cnt;
		logic osc;
	} ubprs_state_t;

	ubprs_state_t state_r;
	ubprs_state_t state_nxt;
	logic tx_led_n;
	logic rx_led_n;

	// next-state logic for the whole block except the two led stretchers
	always_comb
	begin
		state_nxt = state_r;
		// three-stage synchronisers; only stages 1 and 2 are compared
		state_nxt.ext_rst_sync = {state_r.ext_rst_sync[1:0],
			external_reset_n_in};
		state_nxt.supply_sync = {state_r.supply_sync[1:0], supply_good_in};
		state_nxt.psel_sync = {state_r.psel_sync[1:0],
			power_source_select_in};
		state_nxt.test_sync = {state_r.test_sync[1:0], test_mode_in};
		if (state_r.ext_rst_sync[1] == state_r.ext_rst_sync[2])
		begin
			state_nxt.ext_rst_n = state_r.ext_rst_sync[2];
		end
		if (state_r.supply_sync[1] == state_r.supply_sync[2])
		begin
			state_nxt.supply_ok = state_r.supply_sync[2];
		end
		if (state_r.psel_sync[1] == state_r.psel_sync[2])
		begin
			state_nxt.self_powered = state_r.psel_sync[2];
		end
		if (state_r.test_sync[1] == state_r.test_sync[2])
		begin
			state_nxt.test_mode = state_r.test_sync[2];
		end

		case (state_r.rst_state)
			ubprs_pkg::UBPRS_RST_WAIT:
			begin
				state_nxt.rst_cnt = '0;
				if (state_r.supply_ok && state_r.ext_rst_n)
				begin
					state_nxt.rst_state = ubprs_pkg::UBPRS_RST_HOLD;
				end
			end
			ubprs_pkg::UBPRS_RST_HOLD:
			begin
				state_nxt.rst_cnt = state_r.rst_cnt + 1'b1;
				if (state_r.rst_cnt >=
					ubprs_pkg::RST_CNT_W'(RST_HOLD_CYCLES - 1))
				begin
					state_nxt.rst_state = ubprs_pkg::UBPRS_RST_DRIVE;
				end
			end
			ubprs_pkg::UBPRS_RST_DRIVE:
			begin
				state_nxt.rst_cnt = '0;
			end
			default:
			begin
				state_nxt.rst_state = ubprs_pkg::UBPRS_RST_WAIT;
			end
		endcase
		if (!state_r.ext_rst_n || !state_r.supply_ok)
		begin
			state_nxt.rst_state = ubprs_pkg::UBPRS_RST_WAIT;
			state_nxt.rst_cnt = '0;
		end

		if (usb_status_in.suspended || !state_r.ext_rst_n)
		begin
			state_nxt.pwr_en_n = 1'b1;
		end
		else if (usb_status_in.configured)
		begin
			state_nxt.pwr_en_n = 1'b0;
		end

		if (!usb_status_in.suspended)
		begin
			if (state_r.osc_cnt ==
				ubprs_pkg::OSC_CNT_W'(ubprs_pkg::OSC_HALF_CYC - 1))
			begin
				state_nxt.osc_cnt = '0;
				state_nxt.osc = !state_r.osc;
			end
			else
			begin
				state_nxt.osc_cnt = state_r.osc_cnt + 1'b1;
			end
		end
	end

	// state register; pin filters start low, holding reset until seen high
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state_r <= '{ext_rst_sync: '0, supply_sync: '0, psel_sync: '0,
				test_sync: '0, ext_rst_n: 1'b0, supply_ok: 1'b0,
				self_powered: 1'b0, test_mode: 1'b0,
				rst_state: ubprs_pkg::UBPRS_RST_WAIT, rst_cnt: '0,
				pwr_en_n: 1'b1, osc_cnt: '0, osc: 1'b0};
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	ubprs_led_stretch #(.PULSE_CYCLES(LED_PULSE_CYCLES)) u_tx_led
	(
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.active_in(usb_status_in.tx_active),
		.led_n_out(tx_led_n)
	);

	ubprs_led_stretch #(.PULSE_CYCLES(LED_PULSE_CYCLES)) u_rx_led
	(
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.active_in(usb_status_in.rx_active),
		.led_n_out(rx_led_n)
	);

	assign eeprom_serial_clock_out = 1'b0;
	assign eeprom_serial_clock_oe_out = state_r.ext_rst_n;
	assign eeprom_chip_select_oe_out = 1'b0; // protocol engine not here
	assign eeprom_data_io_oe_out = 1'b0;

	// reset output drives high only when released
	assign reset_output_out =
		(state_r.rst_state == ubprs_pkg::UBPRS_RST_DRIVE);
	assign reset_output_oe_out =
		(state_r.rst_state == ubprs_pkg::UBPRS_RST_DRIVE);

	assign suspend_n_out = !usb_status_in.suspended;
	assign power_enable_n_out = state_r.pwr_en_n;
	assign self_powered_out = state_r.self_powered;
	assign test_mode_out = state_r.test_mode;
	assign tx_activity_led_n_oe_out = !tx_led_n;
	assign rx_activity_led_n_oe_out = !rx_led_n;
	assign oscillator_output_out = state_r.osc;
endmodule : ubprs_top

//--- testbench/testbench.sv
// self-checking bench for ubprs_top
// assumes far-side model and checker compiled before it
`timescale 1ns/1ps
module testbench;
	localparam int HOLD = 20;
	// short led stretch so the pulse end is seen in the run
	localparam int PULSE = 16;
	logic exp_ld;
	logic sys_clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic external_reset_n_in = 1'b1;
	logic power_source_select_in = 1'b0;
	logic supply_good_in = 1'b0;
	logic test_mode_in = 1'b0;
	ubprs_pkg::ubprs_usb_status_t usb_status_in = '0;
	logic eeprom_serial_clock_out, eeprom_serial_clock_oe_out;
	logic eeprom_chip_select_oe_out, eeprom_data_io_oe_out;
	logic reset_output_out, reset_output_oe_out, suspend_n_out;
	logic power_enable_n_out, self_powered_out, test_mode_out;
	logic tx_activity_led_n_oe_out, rx_activity_led_n_oe_out;
	logic oscillator_output_out, mcu, load, o_prev;
	int mismatches = 0;
	int comparisons = 0;
	int seed = 34;
	int i;
	int n;
	// bench supplies the reference clock, 100 MHz
	always #5 sys_clk_in = ~sys_clk_in;
	ubprs_top #(.RST_HOLD_CYCLES(HOLD), .LED_PULSE_CYCLES(PULSE))
		dut (.*);
	ubprs_far_side u_far (.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.reset_output_in(reset_output_out),
		.reset_output_oe_in(reset_output_oe_out),
		.power_enable_n_in(power_enable_n_out),
		.mcu_running_out(mcu), .load_powered_out(load));
	task automatic chk(input logic got, input logic exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// expected load power after one status step; suspend wins
	function automatic logic exp_load(input ubprs_pkg::ubprs_usb_status_t s,
		input logic held);
		if (s.suspended)
			return 1'b0;
		else if (s.configured)
			return 1'b1;
		return held;
	endfunction : exp_load
	task automatic tick(input int k);
		repeat (k) @(negedge sys_clk_in);
	endtask : tick
	task automatic final_report();
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report
	// watchdog: whole run is well under 2000 cycles
	initial
	begin
		repeat (5000) @(posedge sys_clk_in);
		mismatches++;
		final_report();
	end
	// main sequence; inputs move on the falling edge
	initial
	begin
		tick(12);
		chk(eeprom_serial_clock_oe_out, 1'b0);
		reset_n_in = 1'b1;
		supply_good_in = 1'b1;
		exp_ld = 1'b0;
		n = 0;
		while (!reset_output_oe_out && n < 200)
		begin
			tick(1);
			n++;
		end
		chk(n >= HOLD && n <= HOLD + 10, 1'b1);
		// the mcu wants the driven level on two samples running
		tick(1);
		chk(mcu, 1'b1);
		chk(eeprom_serial_clock_oe_out, 1'b1);
		chk(eeprom_serial_clock_out, 1'b0);
		// lone one-cycle transmit burst must stay visible, then end
		usb_status_in.tx_active = 1'b1;
		tick(1);
		usb_status_in.tx_active = 1'b0;
		tick(PULSE - 6);
		chk(tx_activity_led_n_oe_out, 1'b1);
		chk(rx_activity_led_n_oe_out, 1'b0);
		tick(8);
		chk(tx_activity_led_n_oe_out, 1'b0);
		// random usb status, bus reset included
		for (i = 0; i < 300; i++)
		begin
			usb_status_in = 5'($random(seed));
			exp_ld = exp_load(usb_status_in, exp_ld);
			tick(1);
			o_prev = oscillator_output_out;
			tick(1);
			chk(suspend_n_out, !usb_status_in.suspended);
			chk(reset_output_oe_out, 1'b1);
			chk(load, exp_ld);
			if (usb_status_in.suspended)
				chk(oscillator_output_out, o_prev);
			if (usb_status_in.tx_active)
				chk(tx_activity_led_n_oe_out, 1'b1);
			if (usb_status_in.rx_active)
				chk(rx_activity_led_n_oe_out, 1'b1);
		end
		usb_status_in = '0;
		tick(20);
		chk(tx_activity_led_n_oe_out, 1'b0);
		chk(rx_activity_led_n_oe_out, 1'b0);
		o_prev = oscillator_output_out;
		tick(8);
		chk(oscillator_output_out, !o_prev);
		// straps both ways; test strap back low after
		for (i = 0; i < 2; i++)
		begin
			power_source_select_in = i[0];
			test_mode_in = i[0];
			tick(6);
			chk(self_powered_out, i[0]);
			chk(test_mode_out, i[0]);
		end
		// test strap held low in normal use
		test_mode_in = 1'b0;
		// pin reset pulse, otherwise held high
		external_reset_n_in = 1'b0;
		tick(8);
		chk(reset_output_oe_out, 1'b0);
		chk(eeprom_serial_clock_oe_out, 1'b0);
		chk(mcu, 1'b0);
		// pin back to its inactive high level
		external_reset_n_in = 1'b1;
		tick(HOLD + 12);
		chk(reset_output_oe_out, 1'b1);
		supply_good_in = 1'b0;
		tick(8);
		chk(reset_output_oe_out, 1'b0);
		final_report();
	end
endmodule : testbench

//--- testbench/ubprs_assertions.sv
// port checker for ubprs_top
// assumes bind onto ubprs_top with its hold parameter
`timescale 1ns/1ps
module ubprs_assertions
#(
	parameter int RST_HOLD_CYCLES = 20
)
(
	// clock, reset, pins
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic external_reset_n_in,
	input wire logic supply_good_in,
	input wire ubprs_pkg::ubprs_usb_status_t usb_status_in,
	// outputs watched
	input wire logic eeprom_serial_clock_oe_out,
	input wire logic eeprom_chip_select_oe_out,
	input wire logic eeprom_data_io_oe_out,
	input wire logic reset_output_out,
	input wire logic reset_output_oe_out,
	input wire logic suspend_n_out,
	input wire logic power_enable_n_out,
	input wire logic tx_activity_led_n_oe_out,
	input wire logic oscillator_output_out
);
	int up_r;
	// good cycles since supply and pin reset both high
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
		if (!reset_n_in)
			up_r <= 0;
		else if (!(supply_good_in && external_reset_n_in))
			up_r <= 0;
		else if (up_r < RST_HOLD_CYCLES + 20)
			up_r <= up_r + 1;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	// pin reset held long enough to pass the filter
	sequence s_pin_low;
		!external_reset_n_in [*4];
	endsequence
	a_eeprom_float:
	assert property (!eeprom_chip_select_oe_out && !eeprom_data_io_oe_out)
		else $error("eeprom pins driven");
	a_eeclk_run:
	assert property ($rose(reset_output_oe_out) |-> eeprom_serial_clock_oe_out)
		else $error("eeprom clock floats");
	a_suspend_ind:
	assert property (suspend_n_out == !usb_status_in.suspended)
		else $error("suspend indicator wrong");
	a_power_on:
	assert property (usb_status_in.configured && !usb_status_in.suspended
		&& eeprom_serial_clock_oe_out |=> !power_enable_n_out)
		else $error("power enable not low");
	a_power_susp:
	assert property (usb_status_in.suspended |=> power_enable_n_out)
		else $error("power enable low in suspend");
	a_rst_early:
	assert property ($rose(reset_output_oe_out) |-> up_r >= RST_HOLD_CYCLES)
		else $error("reset output driven early");
	a_rst_late:
	assert property (up_r == RST_HOLD_CYCLES + 12 |-> reset_output_oe_out
		&& reset_output_out)
		else $error("reset output not driven high");
	a_rst_pin:
	assert property (s_pin_low |-> ##[0:6] !reset_output_oe_out)
		else $error("reset output kept driven");
	a_bus_reset:
	assert property (usb_status_in.bus_reset && reset_output_oe_out
		&& supply_good_in && external_reset_n_in |=> reset_output_oe_out)
		else $error("bus reset hit reset output");
	a_tx_stretch:
	assert property ($fell(usb_status_in.tx_active) |->
		tx_activity_led_n_oe_out [*4])
		else $error("tx led not stretched");
	a_osc_freeze:
	assert property (usb_status_in.suspended [*2] |->
		$stable(oscillator_output_out))
		else $error("oscillator runs in suspend");
endmodule : ubprs_assertions
bind ubprs_top ubprs_assertions #(.RST_HOLD_CYCLES(RST_HOLD_CYCLES)) u_chk (.*);

//--- testbench/ubprs_far_side.sv
// far side: mcu on the reset wire and a load power switch
// assumes pin values and enables as ubprs_top presents them
`timescale 1ns/1ps
module ubprs_far_side
(
	// pins from the device
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic reset_output_in,
	input wire logic reset_output_oe_in,
	input wire logic power_enable_n_in,
	// board view
	output logic mcu_running_out,
	output logic load_powered_out
);
	logic last_r;
	logic wire_lv;
	// no pull on the wire: a floating wire flips every cycle
	assign wire_lv = reset_output_oe_in ? reset_output_in : !last_r;
	// wire memory, cleared with the bench reset so it never stays unknown
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			last_r <= 1'b0;
		end
		else
		begin
			last_r <= wire_lv;
		end
	end
	// mcu runs only on a wire seen high twice running
	assign mcu_running_out = wire_lv && last_r;
	// p-channel switch: load on while enable is low
	assign load_powered_out = !power_enable_n_in;
endmodule : ubprs_far_side
